/* File: hdl/pdm_mic_pkg.sv */
package pdm_mic_pkg;
  // Register indexes (printed offsets are not multiples of four: byte address is index*4)
  localparam logic [7:0] IDX_DETECT_ENABLE_CTRL      = 8'h29;
  localparam logic [7:0] IDX_FLOOR_LEVEL_HIGH        = 8'h2A;
  localparam logic [7:0] IDX_FLOOR_LEVEL_LOW         = 8'h2B;
  localparam logic [7:0] IDX_RESERVED_SLOT_A         = 8'h2C;
  localparam logic [7:0] IDX_RESERVED_SLOT_B         = 8'h2D;
  localparam logic [7:0] IDX_RELATIVE_PULSE_MIN_LOW  = 8'h2E;
  localparam logic [7:0] IDX_PULSE_MIN_HIGH_NIBBLES  = 8'h2F;
  localparam logic [7:0] IDX_ABSOLUTE_PULSE_MIN_LOW  = 8'h30;
  localparam logic [7:0] IDX_ABSOLUTE_THRESHOLD_LOW  = 8'h31;
  localparam logic [7:0] IDX_ABSOLUTE_THRESHOLD_HIGH = 8'h32;
  localparam logic [7:0] IDX_RELATIVE_THRESHOLD      = 8'h33;
  localparam logic [7:0] IDX_UNUSED_SLOT_A           = 8'h35;
  localparam logic [7:0] IDX_UNUSED_SLOT_B           = 8'h36;
  localparam logic [7:0] IDX_LINK_STATUS             = 8'h40;
  localparam logic [7:0] IDX_SAMPLE_INPUT            = 8'h41;

  // Field layouts
  localparam logic [7:0] ENABLE_WRITE_MASK  = 8'h0B;
  localparam int         DETECT_ONE_BIT     = 0;
  localparam int         DETECT_TWO_BIT     = 1;
  localparam int         ANALOG_DETECT_BIT  = 3;
  localparam logic [7:0] FIVE_BIT_MASK      = 8'h1F;
  localparam logic [7:0] RESET_VALUE        = 8'h00;

  // Clock-rate classification, in system clock cycles of link clock period
  localparam int SYS_CLK_MHZ            = 20;
  localparam int SLEEP_FREQ_KHZ         = 200;
  localparam int LOW_POWER_FREQ_KHZ     = 768;
  localparam int LOW_POWER_TOL_KHZ      = 32;
  localparam int SLEEP_PERIOD_CYCLES    = (SYS_CLK_MHZ * 1000) / SLEEP_FREQ_KHZ;
  localparam int LP_MAX_PERIOD_CYCLES   = (SYS_CLK_MHZ * 1000) / (LOW_POWER_FREQ_KHZ - LOW_POWER_TOL_KHZ);
  localparam int LP_MIN_PERIOD_CYCLES   = (SYS_CLK_MHZ * 1000 + LOW_POWER_FREQ_KHZ + LOW_POWER_TOL_KHZ - 1)
                                          / (LOW_POWER_FREQ_KHZ + LOW_POWER_TOL_KHZ);

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_SLEEP      = 2'b00,
    MODE_LOW_POWER  = 2'b01,
    MODE_NORMAL     = 2'b10
  } link_mode_t;

  typedef struct packed {
    logic       valid;
    logic       bit_value;
  } pdm_word_t;

  typedef struct packed {
    logic [12:0] floor_level;
    logic [11:0] relative_pulse_minimum;
    logic [11:0] absolute_pulse_minimum;
    logic [12:0] absolute_threshold;
    logic [7:0]  relative_threshold;
  } detect_cfg_t;
endpackage

/* File: hdl/pdm_mic_output.sv */
// Operation
// - Left channel drives on falling clock edge, right channel on rising edge.
// - After driving its half, device releases the data line to high impedance.
// - Channel select low means right (first half), high means left (second half).
// - Channel select sampled once at power-up; system keeps it steady.
// - Single device changes output on only one edge; line holds last bit.
// - Amplitude encoded as pulse density; alternating bits mean zero signal.
// - Modulator limits peak at digital full scale and keeps running past clipping.
// - Low-power listening entered when clock runs at low-power frequency.
// - Unpowered or sleeping device presents no load on shared data line.
// - While detection active, wake output goes high on sound above threshold.
// - Register 29h holds detect one, detect two, analog enables; others reserved.
// - Multi-byte thresholds and pulse minimums split across 2Ah..33h as laid out.
// - Below sleep limit the device sleeps with data output at high impedance.
`timescale 1ns/1ps
module pdm_mic_output #(
  parameter int ACC_WIDTH = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link pins
  input  wire logic        pdm_clk,
  input  wire logic        channel_select,
  input  wire logic        powered,
  output logic             data_out,
  output logic             data_oe_n,
  // Modulator and detector side
  input  wire logic [ACC_WIDTH-1:0] sample_in,
  input  wire logic        sample_valid,
  output logic             sample_ready,
  input  wire logic        voice_level_above,
  output logic             wake,
  output logic [1:0]       link_mode
);

  // Pin synchronisers: three stages, change accepted when stages two and three agree
  logic [2:0] clk_sync;
  logic [2:0] sel_sync;
  logic [2:0] pwr_sync;
  logic       clk_level;
  logic       sel_level;
  logic       pwr_level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sync <= 3'h0;
      sel_sync <= 3'h0;
      pwr_sync <= 3'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], pdm_clk};
      sel_sync <= {sel_sync[1:0], channel_select};
      pwr_sync <= {pwr_sync[1:0], powered};
    end
  end

  wire clk_agree = clk_sync[1] == clk_sync[2];
  wire sel_agree = sel_sync[1] == sel_sync[2];
  wire pwr_agree = pwr_sync[1] == pwr_sync[2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_level <= 1'b0;
      sel_level <= 1'b0;
      pwr_level <= 1'b0;
    end else begin
      if (clk_agree) clk_level <= clk_sync[2];
      if (sel_agree) sel_level <= sel_sync[2];
      if (pwr_agree) pwr_level <= pwr_sync[2];
    end
  end

  logic clk_level_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) clk_level_d <= 1'b0;
    else          clk_level_d <= clk_level;
  end
  wire rise_edge = clk_level & ~clk_level_d;
  wire fall_edge = ~clk_level & clk_level_d;

  // Channel strap latched once, a few cycles after release so the synchroniser has settled
  logic [2:0] strap_wait;
  logic       strap_taken;
  logic       left_channel;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_wait   <= 3'h0;
      strap_taken  <= 1'b0;
      left_channel <= 1'b0;
    end else if (!strap_taken) begin
      strap_wait <= strap_wait + 3'h1;
      if (strap_wait == 3'h7) begin
        strap_taken  <= 1'b1;
        left_channel <= sel_level;
      end
    end
  end

  // Clock period measurement selects sleep, low-power listening or normal
  localparam int PW = 8;
  localparam logic [PW-1:0] SLEEP_LIMIT = PW'(pdm_mic_pkg::SLEEP_PERIOD_CYCLES);
  localparam logic [PW-1:0] LP_MAX      = PW'(pdm_mic_pkg::LP_MAX_PERIOD_CYCLES);
  localparam logic [PW-1:0] LP_MIN      = PW'(pdm_mic_pkg::LP_MIN_PERIOD_CYCLES);

  logic [PW-1:0] period_count;
  pdm_mic_pkg::link_mode_t mode;
  pdm_mic_pkg::link_mode_t next_mode;

  // Count reads one less than the period in cycles at the rise that ends it
  wire period_expired = period_count >= SLEEP_LIMIT;
  wire period_is_lp   = (period_count >= LP_MIN - PW'(1)) && (period_count < LP_MAX);

  always_comb begin
    next_mode = mode;
    if (period_expired || !pwr_level) begin
      next_mode = pdm_mic_pkg::MODE_SLEEP;
    end else if (rise_edge) begin
      case (mode)
        pdm_mic_pkg::MODE_SLEEP,
        pdm_mic_pkg::MODE_LOW_POWER,
        pdm_mic_pkg::MODE_NORMAL: begin
          next_mode = period_is_lp ? pdm_mic_pkg::MODE_LOW_POWER : pdm_mic_pkg::MODE_NORMAL;
        end
        default: next_mode = pdm_mic_pkg::MODE_SLEEP;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_count <= '0;
      mode         <= pdm_mic_pkg::MODE_SLEEP;
    end else begin
      mode <= next_mode;
      if (rise_edge)            period_count <= '0;
      else if (!period_expired) period_count <= period_count + PW'(1);
    end
  end

  // Two-entry buffer between the sample source and the modulator
  logic [ACC_WIDTH-1:0] buf_mem [2];
  logic                 buf_wr;
  logic                 buf_rd;
  logic [1:0]           buf_count;
  wire  buf_full  = buf_count == 2'd2;
  wire  buf_empty = buf_count == 2'd0;
  wire  mod_step  = left_channel ? fall_edge : rise_edge;
  wire  buf_push  = sample_valid && !buf_full;
  wire  buf_pop   = mod_step && !buf_empty && mode != pdm_mic_pkg::MODE_SLEEP;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_wr       <= 1'b0;
      buf_rd       <= 1'b0;
      buf_count    <= 2'd0;
      sample_ready <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wr] <= sample_in;
        buf_wr          <= ~buf_wr;
      end
      if (buf_pop) buf_rd <= ~buf_rd;
      buf_count    <= buf_count + 2'(buf_push) - 2'(buf_pop);
      sample_ready <= (buf_count + 2'(buf_push) - 2'(buf_pop)) != 2'd2;
    end
  end

  // First-order sigma-delta: bit density follows amplitude, saturates at full scale
  // Held sample repeats when the buffer runs dry, so the stream never stops
  logic [ACC_WIDTH-1:0] held_sample;
  logic [ACC_WIDTH:0]   accum;
  wire  [ACC_WIDTH-1:0] cur_sample = buf_empty ? held_sample : buf_mem[buf_rd];
  wire  [ACC_WIDTH:0]   next_accum = {1'b0, accum[ACC_WIDTH-1:0]} + {1'b0, cur_sample};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_sample <= {1'b1, {(ACC_WIDTH-1){1'b0}}};
      accum       <= '0;
    end else if (mod_step && mode != pdm_mic_pkg::MODE_SLEEP) begin
      held_sample <= cur_sample;
      accum       <= next_accum;
    end
  end

  // Drive in own half only, release for the partner's half and in sleep
  wire own_half = left_channel ? ~clk_level : clk_level;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out  <= 1'b0;
      data_oe_n <= 1'b1;
    end else begin
      if (mod_step && mode != pdm_mic_pkg::MODE_SLEEP) data_out <= next_accum[ACC_WIDTH];
      data_oe_n <= !(own_half && mode != pdm_mic_pkg::MODE_SLEEP && pwr_level);
    end
  end

  // Register file
  logic [7:0] detect_enable_ctrl;
  logic [7:0] floor_level_high;
  logic [7:0] floor_level_low;
  logic [7:0] relative_pulse_min_low;
  logic [7:0] pulse_min_high_nibbles;
  logic [7:0] absolute_pulse_min_low;
  logic [7:0] absolute_threshold_low;
  logic [7:0] absolute_threshold_high;
  logic [7:0] relative_threshold;
  logic [7:0] unused_slot_a;
  logic [7:0] unused_slot_b;

  pdm_mic_pkg::detect_cfg_t cfg;
  assign cfg.floor_level            = {floor_level_high[4:0], floor_level_low};
  assign cfg.relative_pulse_minimum = {pulse_min_high_nibbles[3:0], relative_pulse_min_low};
  assign cfg.absolute_pulse_minimum = {pulse_min_high_nibbles[7:4], absolute_pulse_min_low};
  assign cfg.absolute_threshold     = {absolute_threshold_high[4:0], absolute_threshold_low};
  assign cfg.relative_threshold     = relative_threshold;

  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  // Write channel: address and data accepted in either order, response after both
  logic [11:0] aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  wire         do_write = aw_held && w_held && !s_axi_bvalid;
  wire  [7:0]  widx = reg_index(aw_addr);
  wire         lane0 = w_strb[0];
  wire  [7:0]  wbyte = w_data[7:0];

  wire  wr_map = widx inside {pdm_mic_pkg::IDX_DETECT_ENABLE_CTRL, pdm_mic_pkg::IDX_FLOOR_LEVEL_HIGH,
                              pdm_mic_pkg::IDX_FLOOR_LEVEL_LOW, pdm_mic_pkg::IDX_RESERVED_SLOT_A,
                              pdm_mic_pkg::IDX_RESERVED_SLOT_B, pdm_mic_pkg::IDX_RELATIVE_PULSE_MIN_LOW,
                              pdm_mic_pkg::IDX_PULSE_MIN_HIGH_NIBBLES, pdm_mic_pkg::IDX_ABSOLUTE_PULSE_MIN_LOW,
                              pdm_mic_pkg::IDX_ABSOLUTE_THRESHOLD_LOW, pdm_mic_pkg::IDX_ABSOLUTE_THRESHOLD_HIGH,
                              pdm_mic_pkg::IDX_RELATIVE_THRESHOLD, pdm_mic_pkg::IDX_UNUSED_SLOT_A,
                              pdm_mic_pkg::IDX_UNUSED_SLOT_B, pdm_mic_pkg::IDX_LINK_STATUS,
                              pdm_mic_pkg::IDX_SAMPLE_INPUT} && aw_addr[11:10] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr       <= 12'h000;
      aw_held       <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pdm_mic_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? pdm_mic_pkg::AXI_OKAY : pdm_mic_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_enable_ctrl      <= pdm_mic_pkg::RESET_VALUE;
      floor_level_high        <= pdm_mic_pkg::RESET_VALUE;
      floor_level_low         <= pdm_mic_pkg::RESET_VALUE;
      relative_pulse_min_low  <= pdm_mic_pkg::RESET_VALUE;
      pulse_min_high_nibbles  <= pdm_mic_pkg::RESET_VALUE;
      absolute_pulse_min_low  <= pdm_mic_pkg::RESET_VALUE;
      absolute_threshold_low  <= pdm_mic_pkg::RESET_VALUE;
      absolute_threshold_high <= pdm_mic_pkg::RESET_VALUE;
      relative_threshold      <= pdm_mic_pkg::RESET_VALUE;
      unused_slot_a           <= pdm_mic_pkg::RESET_VALUE;
      unused_slot_b           <= pdm_mic_pkg::RESET_VALUE;
    end else if (do_write && lane0 && aw_addr[11:10] == 2'b00) begin
      case (widx)
        pdm_mic_pkg::IDX_DETECT_ENABLE_CTRL:      detect_enable_ctrl <= wbyte & pdm_mic_pkg::ENABLE_WRITE_MASK;
        pdm_mic_pkg::IDX_FLOOR_LEVEL_HIGH:        floor_level_high <= wbyte & pdm_mic_pkg::FIVE_BIT_MASK;
        pdm_mic_pkg::IDX_FLOOR_LEVEL_LOW:         floor_level_low <= wbyte;
        pdm_mic_pkg::IDX_RELATIVE_PULSE_MIN_LOW:  relative_pulse_min_low <= wbyte;
        pdm_mic_pkg::IDX_PULSE_MIN_HIGH_NIBBLES:  pulse_min_high_nibbles <= wbyte;
        pdm_mic_pkg::IDX_ABSOLUTE_PULSE_MIN_LOW:  absolute_pulse_min_low <= wbyte;
        pdm_mic_pkg::IDX_ABSOLUTE_THRESHOLD_LOW:  absolute_threshold_low <= wbyte;
        pdm_mic_pkg::IDX_ABSOLUTE_THRESHOLD_HIGH: absolute_threshold_high <= wbyte & pdm_mic_pkg::FIVE_BIT_MASK;
        pdm_mic_pkg::IDX_RELATIVE_THRESHOLD:      relative_threshold <= wbyte;
        // Kept as plain storage; the analog path that uses them lies outside this block
        pdm_mic_pkg::IDX_UNUSED_SLOT_A:           unused_slot_a <= wbyte;
        pdm_mic_pkg::IDX_UNUSED_SLOT_B:           unused_slot_b <= wbyte;
        default: ;
      endcase
    end
  end

  // Read channel
  logic [7:0] read_byte;
  wire  [7:0] ridx = reg_index(s_axi_araddr);
  always_comb begin
    read_byte = 8'h00;
    case (ridx)
      pdm_mic_pkg::IDX_DETECT_ENABLE_CTRL:      read_byte = detect_enable_ctrl;
      pdm_mic_pkg::IDX_FLOOR_LEVEL_HIGH:        read_byte = floor_level_high;
      pdm_mic_pkg::IDX_FLOOR_LEVEL_LOW:         read_byte = floor_level_low;
      pdm_mic_pkg::IDX_RELATIVE_PULSE_MIN_LOW:  read_byte = relative_pulse_min_low;
      pdm_mic_pkg::IDX_PULSE_MIN_HIGH_NIBBLES:  read_byte = pulse_min_high_nibbles;
      pdm_mic_pkg::IDX_ABSOLUTE_PULSE_MIN_LOW:  read_byte = absolute_pulse_min_low;
      pdm_mic_pkg::IDX_ABSOLUTE_THRESHOLD_LOW:  read_byte = absolute_threshold_low;
      pdm_mic_pkg::IDX_ABSOLUTE_THRESHOLD_HIGH: read_byte = absolute_threshold_high;
      pdm_mic_pkg::IDX_RELATIVE_THRESHOLD:      read_byte = relative_threshold;
      pdm_mic_pkg::IDX_UNUSED_SLOT_A:           read_byte = unused_slot_a;
      pdm_mic_pkg::IDX_UNUSED_SLOT_B:           read_byte = unused_slot_b;
      pdm_mic_pkg::IDX_LINK_STATUS:             read_byte = {3'h0, wake, left_channel, strap_taken, mode};
      pdm_mic_pkg::IDX_SAMPLE_INPUT:            read_byte = {6'h00, buf_count};
      default:                                  read_byte = 8'h00;
    endcase
  end

  wire rd_map = ridx inside {pdm_mic_pkg::IDX_DETECT_ENABLE_CTRL, pdm_mic_pkg::IDX_FLOOR_LEVEL_HIGH,
                             pdm_mic_pkg::IDX_FLOOR_LEVEL_LOW, pdm_mic_pkg::IDX_RESERVED_SLOT_A,
                             pdm_mic_pkg::IDX_RESERVED_SLOT_B, pdm_mic_pkg::IDX_RELATIVE_PULSE_MIN_LOW,
                             pdm_mic_pkg::IDX_PULSE_MIN_HIGH_NIBBLES, pdm_mic_pkg::IDX_ABSOLUTE_PULSE_MIN_LOW,
                             pdm_mic_pkg::IDX_ABSOLUTE_THRESHOLD_LOW, pdm_mic_pkg::IDX_ABSOLUTE_THRESHOLD_HIGH,
                             pdm_mic_pkg::IDX_RELATIVE_THRESHOLD, pdm_mic_pkg::IDX_UNUSED_SLOT_A,
                             pdm_mic_pkg::IDX_UNUSED_SLOT_B, pdm_mic_pkg::IDX_LINK_STATUS,
                             pdm_mic_pkg::IDX_SAMPLE_INPUT} && s_axi_araddr[11:10] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pdm_mic_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, read_byte};
        s_axi_rresp  <= rd_map ? pdm_mic_pkg::AXI_OKAY : pdm_mic_pkg::AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Wake: any digital variant armed, listening in low-power mode, level above threshold
  logic [2:0] level_sync;
  wire level_agree = level_sync[1] == level_sync[2];
  wire digital_armed = detect_enable_ctrl[pdm_mic_pkg::DETECT_ONE_BIT] |
                       detect_enable_ctrl[pdm_mic_pkg::DETECT_TWO_BIT];
  wire detect_active = digital_armed && mode == pdm_mic_pkg::MODE_LOW_POWER;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_sync <= 3'h0;
      wake       <= 1'b0;
      link_mode  <= pdm_mic_pkg::MODE_SLEEP;
    end else begin
      level_sync <= {level_sync[1:0], voice_level_above};
      link_mode  <= mode;
      if (!detect_active) wake <= 1'b0;
      else if (level_agree) wake <= level_sync[2];
    end
  end

endmodule // pdm_mic_output

/* File: bench/pdm_mic_output_assertions.sv */
`timescale 1ns/1ps
module pdm_mic_output_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        powered,
  input wire logic        data_oe_n,
  input wire logic        wake,
  input wire logic [1:0]  link_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A clock stopped in the own half keeps the line driven until the sleep timeout
  logic [7:0] drive_run;
  always_ff @(posedge aclk) drive_run <= (!aresetn || data_oe_n) ? 8'h00 : drive_run + 8'h01;
  property p_b_after_aw; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
  a_b_after_aw: assert property (p_b_after_aw) else $error("write response missing");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_next: assert property (p_r_next) else $error("read data late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_sleep_released; link_mode == pdm_mic_pkg::MODE_SLEEP |-> data_oe_n; endproperty
  a_sleep_released: assert property (p_sleep_released) else $error("driving while asleep");
  property p_unpowered; !powered [*6] |-> data_oe_n; endproperty
  a_unpowered: assert property (p_unpowered) else $error("driving while unpowered");
  property p_wake_mode; wake |-> link_mode == pdm_mic_pkg::MODE_LOW_POWER || $past(link_mode) == 2'h1; endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake outside listening");
  property p_drive_bounded; drive_run <= 8'h68; endproperty
  a_drive_bounded: assert property (p_drive_bounded) else $error("line never released");
  c_wake: cover property ($rose(wake));
  c_low_power: cover property (link_mode == pdm_mic_pkg::MODE_LOW_POWER);
  c_drive: cover property ($fell(data_oe_n));
endmodule // pdm_mic_output_assertions

/* File: bench/pdm_codec_model.sv */
`timescale 1ns/1ps
module pdm_codec_model (
  output logic      pdm_clk,
  input  wire logic run,
  input  var int   half_ns,
  input  wire logic left,
  input  wire logic data_out,
  input  wire logic data_oe_n,
  output int        ones,
  output int        floats,
  output int        clash
);
  logic last = 1'b0;
  logic line;
  // No pull on the line: released reads as the opposite of the last bit
  assign line = data_oe_n ? ~last : data_out;
  initial begin
    pdm_clk = 1'b0;
    ones = 0;
    floats = 0;
    clash = 0;
    forever begin
      if (run) begin
        #(half_ns) pdm_clk = 1'b1;
        #(half_ns) pdm_clk = 1'b0;
      end else begin
        #50;
      end
    end
  end
  always @(data_out or data_oe_n) if (!data_oe_n) last = data_out;
  // Own half ends on the opposite edge; the other half must be released
  always @(pdm_clk) begin
    if (pdm_clk === left) begin
      ones = ones + int'(line);
      floats = floats + int'(data_oe_n);
    end else begin
      clash = clash + int'(!data_oe_n);
    end
  end
endmodule // pdm_codec_model

/* File: bench/pdm_mic_output_tb_top.sv */
`timescale 1ns/1ps
module pdm_mic_output_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, pdm_clk, data_out, data_oe_n, sample_ready, wake;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, link_mode;
  logic        channel_select = 1'b1, powered = 1'b1, sample_valid = 1'b1, voice_level_above = 1'b0;
  logic [15:0] sample_in = 16'h8000;
  logic        run = 1'b0, chan = 1'b1;
  int          half = 500, ones, floats, clash, n_errors = 0, compares = 0, cyc = 0;
  logic [7:0]  ri [11] = '{8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33};
  logic [7:0]  em [11] = '{8'h0B, 8'h1F, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF};
  logic [7:0]  ul [5] = '{8'h5C, 8'h3E, 8'h6F, 8'h3B, 8'h4C};
  pdm_mic_output dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pdm_clk, .channel_select,
    .powered, .data_out, .data_oe_n, .sample_in, .sample_valid, .sample_ready, .voice_level_above, .wake, .link_mode);
  pdm_codec_model codec (.pdm_clk, .run, .half_ns(half), .left(chan), .data_out, .data_oe_n, .ones, .floats, .clash);
  always #25 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [1:0] er = pdm_mic_pkg::AXI_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] i, input logic [1:0] er = pdm_mic_pkg::AXI_OKAY);
    @(posedge aclk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic rst(input logic sel);
    @(posedge aclk);
    aresetn <= 1'b0;
    channel_select <= sel;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
  endtask
  // Warm up past the two buffered samples, then count 32 captured bits
  task automatic link(input int h, input logic [15:0] v, input int lo, input int hi);
    int o, f, c;
    @(posedge aclk);
    sample_in <= v;
    half = h;
    run = 1'b1;
    repeat (8) @(posedge pdm_clk);
    o = ones;
    f = floats;
    c = clash;
    repeat (32) @(posedge pdm_clk);
    chk("ones", 1, 32'((ones - o >= lo) && (ones - o <= hi)));
    chk("floats", f, floats);
    chk("clash", c, clash);
  endtask
  task automatic vset(input logic v, input logic e);
    @(posedge aclk);
    voice_level_above <= v;
    repeat (12) @(posedge aclk);
    chk("wake", {31'h0, e}, {31'h0, wake});
  endtask
  initial begin
    rst(1'b1);
    for (int k = 0; k < 5; k++) wr(ul[k], 8'h00, pdm_mic_pkg::AXI_SLVERR);
    for (int k = 0; k < 11; k++) begin
      rd(ri[k]);
      chk("reset", 0, d);
      if (em[k] != 8'h00) wr(ri[k], 8'hFF);
      rd(ri[k]);
      chk("field", {24'h0, em[k]}, d);
    end
    rd(8'h34, pdm_mic_pkg::AXI_SLVERR);
    $display("test registers done");
    rd(8'h40);
    chk("left", 32'h8, d & 32'h8);
    link(500, 16'h8000, 14, 18);
    link(500, 16'hFFFF, 30, 33);
    link(500, 16'h0000, 0, 2);
    chk("normal", pdm_mic_pkg::MODE_NORMAL, link_mode);
    $display("test left link done");
    wr(8'h29, 8'h01);
    link(650, 16'h8000, 14, 18);
    chk("listening", pdm_mic_pkg::MODE_LOW_POWER, link_mode);
    vset(1'b1, 1'b1);
    vset(1'b0, 1'b0);
    wr(8'h29, 8'h00);
    vset(1'b1, 1'b0);
    vset(1'b0, 1'b0);
    $display("test wake done");
    run = 1'b0;
    repeat (150) @(posedge aclk);
    chk("sleep", pdm_mic_pkg::MODE_SLEEP, link_mode);
    chk("released", 1, data_oe_n);
    chk("full", 0, sample_ready);
    rd(8'h41);
    chk("fill", 2, d);
    sample_valid <= 1'b0;
    half = 500;
    run = 1'b1;
    repeat (8) @(posedge pdm_clk);
    rd(8'h41);
    chk("drained", 0, d);
    powered <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("unpowered", 1, data_oe_n);
    powered <= 1'b1;
    $display("test sleep and buffer done");
    run = 1'b0;
    chan = 1'b0;
    rst(1'b0);
    channel_select <= 1'b1;
    sample_valid <= 1'b1;
    rd(8'h40);
    chk("right", 0, d & 32'h8);
    link(500, 16'h8000, 14, 18);
    $display("test right link done");
    print_verdict();
  end
endmodule // pdm_mic_output_tb_top
bind pdm_mic_output pdm_mic_output_assertions chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .powered, .data_oe_n, .wake, .link_mode);
